/* pkg/acc_pkg.sv */
package acc_pkg;
  localparam logic [7:0] ACC_CTRL_ADDR     = 8'he8;
  localparam logic [7:0] ACC_CTRL_RESET    = 8'h00;
  localparam int         ACC_BIT_ON        = 7;
  localparam int         ACC_BIT_TRACK     = 6;
  localparam int         ACC_BIT_DONE      = 5;
  localparam int         ACC_BIT_ACTIVE    = 4;
  localparam int         ACC_BIT_SRC_HI    = 3;
  localparam int         ACC_BIT_SRC_LO    = 2;
  localparam int         ACC_BIT_WINDOW    = 1;
  localparam int         ACC_BIT_ALIGN     = 0;
  localparam logic [1:0] ACC_SRC_SOFTWARE  = 2'h0;
  localparam logic [1:0] ACC_SRC_TIMER3    = 2'h1;
  localparam logic [1:0] ACC_SRC_STROBE    = 2'h2;
  localparam logic [1:0] ACC_SRC_TIMER2    = 2'h3;
  localparam int         ACC_TRACK_SAR_CLKS = 3;
  localparam int         ACC_CONV_SAR_CLKS  = 11;
  localparam int         ACC_SAR_DIV        = 4;
  localparam int         ACC_RESULT_BITS    = 10;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_TRACK,
    ACC_CONVERT
  } acc_state_t;
endpackage

/* design/acc_result_store.sv */
`timescale 1ns/1ps
module acc_result_store
  import acc_pkg::*;
#(
  parameter int RESULT_BITS = acc_pkg::ACC_RESULT_BITS
)(
  // Clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_in,
  // Result capture
  input  wire logic                   load_in,
  input  wire logic [RESULT_BITS-1:0] result_in,
  input  wire logic                   left_align_sel_in,
  // Data registers
  output logic      [7:0]             data_high_out,
  output logic      [7:0]             data_low_out
);
  typedef struct packed {
    logic [RESULT_BITS-1:0] raw;
    logic [7:0]             high;
    logic [7:0]             low;
  } acc_store_t;

  acc_store_t s_q;
  acc_store_t s_d;
  logic [15:0] right_w;
  logic [15:0] left_w;

  always_comb
  begin
    s_d = s_q;
    if (load_in)
    begin
      s_d.raw = result_in;
    end
    right_w = 16'(s_d.raw);
    left_w  = right_w << (16 - RESULT_BITS);
    if (left_align_sel_in)
    begin
      s_d.high = left_w[15:8];
      s_d.low  = left_w[7:0];
    end
    else
    begin
      s_d.high = right_w[15:8];
      s_d.low  = right_w[7:0];
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign data_high_out = s_q.high;
  assign data_low_out  = s_q.low;
endmodule

/* design/acc_control.sv */
`timescale 1ns/1ps
module acc_control
  import acc_pkg::*;
#(
  parameter int SAR_DIV        = acc_pkg::ACC_SAR_DIV,
  parameter int CONV_SAR_CLKS  = acc_pkg::ACC_CONV_SAR_CLKS,
  parameter int RESULT_BITS    = acc_pkg::ACC_RESULT_BITS
)(
  // Clock and reset
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_in,
  // Special function register port
  input  wire logic [7:0]             sfr_addr_in,
  input  wire logic                   sfr_wr_in,
  input  wire logic                   sfr_rd_in,
  input  wire logic [7:0]             sfr_wdata_in,
  output logic      [7:0]             sfr_rdata_out,
  // Start sources
  input  wire logic                   timer3_overflow_in,
  input  wire logic                   timer2_overflow_in,
  input  wire logic                   ext_convert_strobe_in,
  // Converter core
  input  wire logic [RESULT_BITS-1:0] sar_result_in,
  input  wire logic                   window_hit_in,
  output logic                        converter_on_out,
  output logic                        tracking_out,
  output logic                        converting_out,
  // Interrupt
  input  wire logic                   conv_irq_enable_in,
  output logic                        conv_irq_out,
  // Data registers
  output logic      [7:0]             data_high_out,
  output logic      [7:0]             data_low_out
);
  import acc_pkg::*;

  typedef struct packed {
    logic [7:0]  ctrl;
    acc_state_t  state;
    logic [7:0]  div;
    logic [7:0]  sar_cnt;
    logic        strobe_prev;
    logic        irq;
    logic [7:0]  rdata;
  } acc_regs_t;

  acc_regs_t r_q;
  acc_regs_t r_d;

  logic       ctrl_wr;
  logic       sar_tick;
  logic       enabled;
  logic       track_mode;
  logic [1:0] src;
  logic       start_evt;
  logic       strobe_rise;
  logic       conv_end;
  logic       busy_now;
  logic       busy_next;

  assign ctrl_wr    = sfr_wr_in && (sfr_addr_in == ACC_CTRL_ADDR);
  assign enabled    = r_q.ctrl[ACC_BIT_ON];
  assign track_mode = r_q.ctrl[ACC_BIT_TRACK];
  assign src        = r_q.ctrl[ACC_BIT_SRC_HI:ACC_BIT_SRC_LO];
  assign sar_tick   = (r_q.div == 8'(SAR_DIV - 1));
  assign strobe_rise = ext_convert_strobe_in && !r_q.strobe_prev;

  always_comb
  begin
    case (src)
      ACC_SRC_SOFTWARE: start_evt = ctrl_wr && sfr_wdata_in[ACC_BIT_ACTIVE];
      ACC_SRC_TIMER3:   start_evt = timer3_overflow_in;
      ACC_SRC_STROBE:   start_evt = strobe_rise;
      ACC_SRC_TIMER2:   start_evt = timer2_overflow_in;
      default:          start_evt = 1'b0;
    endcase
  end

  assign conv_end = (r_q.state == ACC_CONVERT) && sar_tick && (r_q.sar_cnt == 8'(CONV_SAR_CLKS - 1));

  always_comb
  begin
    r_d = r_q;
    r_d.strobe_prev = ext_convert_strobe_in;
    r_d.div = sar_tick ? 8'h00 : r_q.div + 8'h01;
    if (ctrl_wr)
    begin
      // Busy is owned by the state machine; flags take the written value.
      r_d.ctrl[7:6] = sfr_wdata_in[7:6];
      r_d.ctrl[5]   = sfr_wdata_in[5];
      r_d.ctrl[3:0] = sfr_wdata_in[3:0];
    end
    // A completion in the same cycle as a clearing write still sets the flag.
    if (conv_end)
    begin
      r_d.ctrl[ACC_BIT_DONE] = 1'b1;
      if (window_hit_in)
      begin
        r_d.ctrl[ACC_BIT_WINDOW] = 1'b1;
      end
    end
    case (r_q.state)
      ACC_IDLE:
      begin
        if (enabled && start_evt)
        begin
          r_d.sar_cnt = 8'h00;
          // Triggered tracking precedes conversion except in strobe mode, where the low phase was the track.
          if (track_mode && src != ACC_SRC_STROBE)
          begin
            r_d.state = ACC_TRACK;
          end
          else
          begin
            r_d.state = ACC_CONVERT;
          end
        end
      end
      ACC_TRACK:
      begin
        if (sar_tick)
        begin
          r_d.sar_cnt = r_q.sar_cnt + 8'h01;
          if (r_q.sar_cnt == 8'(ACC_TRACK_SAR_CLKS - 1))
          begin
            r_d.sar_cnt = 8'h00;
            r_d.state   = ACC_CONVERT;
          end
        end
      end
      ACC_CONVERT:
      begin
        if (sar_tick)
        begin
          r_d.sar_cnt = r_q.sar_cnt + 8'h01;
        end
        if (conv_end)
        begin
          r_d.state = ACC_IDLE;
        end
      end
      default:
      begin
        r_d.state = ACC_IDLE;
      end
    endcase
    // Shutdown follows the written enable at once, so no conversion outlives its enable.
    if (!r_d.ctrl[ACC_BIT_ON])
    begin
      r_d.state = ACC_IDLE;
    end
    busy_now  = (r_q.state != ACC_IDLE);
    busy_next = (r_d.state != ACC_IDLE);
    r_d.ctrl[ACC_BIT_ACTIVE] = busy_next;
    r_d.irq = busy_now && !busy_next && conv_irq_enable_in;
    r_d.rdata = (sfr_rd_in && sfr_addr_in == ACC_CTRL_ADDR) ? r_q.ctrl : 8'h00;
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      r_q       <= '0;
      r_q.ctrl  <= ACC_CTRL_RESET;
      r_q.state <= ACC_IDLE;
      // The strobe idles high; starting low here would fake a rising edge after reset.
      r_q.strobe_prev <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  always_comb
  begin
    tracking_out = 1'b0;
    if (enabled)
    begin
      if (r_q.state == ACC_TRACK)
      begin
        tracking_out = 1'b1;
      end
      else if (r_q.state == ACC_IDLE && !track_mode)
      begin
        tracking_out = 1'b1;
      end
      else if (r_q.state == ACC_IDLE && src == ACC_SRC_STROBE)
      begin
        tracking_out = !ext_convert_strobe_in;
      end
    end
  end

  assign converter_on_out = enabled;
  assign converting_out   = (r_q.state == ACC_CONVERT);
  assign conv_irq_out     = r_q.irq;
  assign sfr_rdata_out    = r_q.rdata;

  acc_result_store #(
    .RESULT_BITS (RESULT_BITS)
  ) u_store (
    .clk_sys_in        (clk_sys_in),
    .reset_in          (reset_in),
    .load_in           (conv_end),
    .result_in         (sar_result_in),
    .left_align_sel_in (r_q.ctrl[ACC_BIT_ALIGN]),
    .data_high_out     (data_high_out),
    .data_low_out      (data_low_out)
  );
endmodule

/* verif/acc_control_chk.sv */
`timescale 1ns/1ps
module acc_control_chk (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       reset_in,
  // Register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  // Timer starts, converter status and interrupt
  input wire logic       timer3_overflow_in,
  input wire logic       timer2_overflow_in,
  input wire logic       converter_on_out,
  input wire logic       tracking_out,
  input wire logic       converting_out,
  input wire logic       conv_irq_enable_in,
  input wire logic       conv_irq_out
);
  logic rd_ctrl;
  logic wr_ctrl;
  assign rd_ctrl = sfr_rd_in && sfr_addr_in == 8'he8;
  assign wr_ctrl = sfr_wr_in && sfr_addr_in == 8'he8;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  a_off_idle: assert property (!converter_on_out |-> !converting_out)
    else $error("converting while disabled");
  a_read_enable: assert property (rd_ctrl |=> sfr_rdata_out[7] == $past(converter_on_out))
    else $error("enable bit read differs from enable output");
  a_busy_read: assert property (rd_ctrl && converting_out |=> sfr_rdata_out[4])
    else $error("busy bit low during conversion");
  a_idle_read: assert property (rd_ctrl && !converting_out && !tracking_out |=> !sfr_rdata_out[4])
    else $error("busy bit high while idle");
  a_foreign_read: assert property (sfr_rd_in && sfr_addr_in != 8'he8 |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read returned data");
  a_irq_masked: assert property (!conv_irq_enable_in && !$past(conv_irq_enable_in) |-> !conv_irq_out)
    else $error("interrupt while disabled");
  a_irq_single: assert property (conv_irq_out |=> !conv_irq_out)
    else $error("interrupt longer than one cycle");
  a_sw_start: assert property (wr_ctrl && sfr_wdata_in == 8'h90 && converter_on_out && !converting_out
    |=> converting_out)
    else $error("software start ignored");
  // A same-cycle timer pulse could start legally, so it is excluded here.
  a_mode_refuse: assert property (wr_ctrl && sfr_wdata_in[4] && sfr_wdata_in[3:2] != 2'h0 && !converting_out
    && !tracking_out && !timer3_overflow_in && !timer2_overflow_in |=> !converting_out)
    else $error("busy write started a conversion");
endmodule

bind acc_control acc_control_chk u_acc_control_chk (.clk_sys_in, .reset_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
  .sfr_wdata_in, .sfr_rdata_out, .timer3_overflow_in, .timer2_overflow_in, .converter_on_out, .tracking_out,
  .converting_out, .conv_irq_enable_in, .conv_irq_out);

/* verif/test_adc_conversion_control.sv */
`timescale 1ns/1ps
module test_adc_conversion_control;
  import acc_pkg::*;
  logic        clk_sys_in;
  logic        reset_in;
  logic        wr, rd, hit, irq_en, irq, on, trk, conv, seen;
  logic [2:0]  ev;
  logic [7:0]  addr, wdata, rdata, dh, dl;
  logic [9:0]  res;
  logic [31:0] seed = 32'hd97a;
  int          n_mismatch, n_tests, n_irq, exp_irq, cyc, n_trk, n_conv;
  logic [9:0]  m;
  logic [9:0]  exp_q[$];
  // A free-running SAR divider puts the first tick anywhere within one period.
  localparam int TRK_MIN  = (ACC_TRACK_SAR_CLKS - 1) * ACC_SAR_DIV + 1;
  localparam int TRK_MAX  = ACC_TRACK_SAR_CLKS * ACC_SAR_DIV;
  localparam int CONV_MIN = (ACC_CONV_SAR_CLKS - 1) * ACC_SAR_DIV + 1;
  localparam int CONV_MAX = ACC_CONV_SAR_CLKS * ACC_SAR_DIV;
  // Strobe idles high, so ev[1] drives it inverted.
  acc_control u_acc_control (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .timer3_overflow_in(ev[0]),
    .timer2_overflow_in(ev[2]), .ext_convert_strobe_in(~ev[1]), .sar_result_in(res), .window_hit_in(hit),
    .converter_on_out(on), .tracking_out(trk), .converting_out(conv), .conv_irq_enable_in(irq_en),
    .conv_irq_out(irq), .data_high_out(dh), .data_low_out(dl));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_sys_in);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_in);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys_in);
    rd = 1'b0;
    chk("ctrl", e, rdata);
  endtask
  // Long enough for three tracking ticks plus a full conversion; sampling starts at the caller's edge.
  task automatic watch();
    seen = 1'b0;
    n_trk = 0;
    n_conv = 0;
    repeat (100)
    begin
      seen = seen | conv;
      n_trk += int'(trk);
      n_conv += int'(conv);
      @(negedge clk_sys_in);
    end
  endtask
  task automatic fire(input int k, input logic [7:0] c);
    if (k == 0)
      wreg(8'he8, c | 8'h10);
    else
    begin
      @(negedge clk_sys_in);
      ev[k-1] = 1'b1;
      repeat (k == 2 ? 4 : 1) @(negedge clk_sys_in);
      if (k == 2)
        chk("tracking", 8'(c[3:2] == ACC_SRC_STROBE), 8'(trk));
      ev = 3'h0;
    end
  endtask
  initial
  begin
    clk_sys_in = 0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  always @(negedge clk_sys_in)
  begin
    cyc++;
    if (irq === 1'b1)
      n_irq++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    logic [7:0] c;
    {addr, wdata, wr, rd, ev, hit, irq_en, res} = '0;
    reset_in = 1;
    repeat (20) @(negedge clk_sys_in);
    reset_in = 0;
    rreg(8'he8, 8'h00);
    wreg(8'he9, 8'h55);
    rreg(8'he8, 8'h00);
    rreg(8'h00, 8'h00);
    wreg(8'he8, 8'h80);
    chk("tracking", 8'h01, 8'(trk));
    chk("converter_on", 8'h01, 8'(on));
    seed = lfsr(seed);
    res = seed[9:0];
    hit = 1;
    irq_en = 1;
    wreg(8'he8, 8'h90);
    rreg(8'he8, 8'h90);
    watch();
    exp_q.push_back(res);
    exp_irq++;
    rreg(8'he8, 8'ha2);
    chk("data_high", {6'h0, res[9:8]}, dh);
    wreg(8'he8, 8'h81);
    rreg(8'he8, 8'h81);
    chk("data_high", res[9:2], dh);
    chk("data_low", {res[1:0], 6'h0}, dl);
    hit = 0;
    irq_en = 0;
    wreg(8'he8, 8'h90);
    wreg(8'he8, 8'h00);
    rreg(8'he8, 8'h00);
    chk("converter_on", 8'h00, 8'(on));
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 4; k++)
      begin
        seed = lfsr(seed);
        res = seed[9:0];
        irq_en = seed[10];
        c = 8'hc0 | 8'(s << 2);
        wreg(8'he8, c);
        fire(k, c);
        watch();
        exp_irq += int'(s == k && irq_en);
        if (s == k)
          exp_q.push_back(res);
        m = exp_q[$];
        chk("started", 8'(s == k), 8'(seen));
        chk("track_cycles", 8'(s == k && s != 2), 8'(n_trk >= TRK_MIN && n_trk <= TRK_MAX));
        chk("convert_cycles", 8'(s == k), 8'(n_conv >= CONV_MIN && n_conv <= CONV_MAX));
        rreg(8'he8, c | (s == k ? 8'h20 : 8'h00));
        chk("data_low", m[7:0], dl);
        chk("data_high", {6'h0, m[9:8]}, dh);
      end
    chk("irq_count", 8'(exp_irq), 8'(n_irq));
    @(negedge clk_sys_in);
    reset_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    reset_in = 1'b0;
    rreg(8'he8, 8'h00);
    chk("data_low", 8'h00, dl);
    chk("converter_on", 8'h00, 8'(on));
    end_of_test();
  end
endmodule
